// File: rtl/mtr_pkg.sv
//****************************************************************************
// Shared constants for the motion task I/O and ring configuration block.
//****************************************************************************
package mtr_pkg;

   // APB address width and register byte offsets.
   localparam int          ADDR_W         = 12;
   localparam logic [11:0] REG_CFG_OFS    = 12'h000;
   localparam logic [11:0] REG_STATUS_OFS = 12'h004;

   // Field positions inside the configuration register.
   localparam int STATION_LSB = 0;
   localparam int STATION_W   = 6;
   localparam int RATE_LSB    = 8;
   localparam int RATE_W      = 5;
   localparam int LENGTH_LSB  = 16;
   localparam int LENGTH_W    = 8;
   localparam int IO_EN_BIT   = 31;

   // Field positions inside the status register.
   localparam int ST_TARGET_BIT = 0;
   localparam int ST_SEQ_BIT    = 1;
   localparam int ST_FOLLOW_BIT = 2;
   localparam int ST_FLAG_LSB   = 3;
   localparam int ST_AMP_BIT    = 9;
   localparam int ST_COMM_BIT   = 10;
   localparam int ST_LIGHT_BIT  = 11;
   localparam int ST_BAND_LSB   = 12;
   localparam int ST_TASK_LSB   = 16;

   // Values after reset.
   localparam logic [5:0] STATION_RST = 6'h00;
   localparam logic [4:0] RATE_RST    = 5'h02;
   localparam logic [7:0] LENGTH_RST  = 8'h00;
   localparam logic       IO_EN_RST   = 1'b1;

   // Legal station range and ring rate codes.
   localparam logic [6:0] STATION_MAX = 7'h3f;
   localparam logic [4:0] RATE_2M     = 5'h02;
   localparam logic [4:0] RATE_4M     = 5'h04;
   localparam logic [4:0] RATE_8M     = 5'h08;
   localparam logic [4:0] RATE_16M    = 5'h10;

   // Cable length band limits in metres.
   localparam logic [7:0] LEN_MID_MIN  = 8'h0f;
   localparam logic [7:0] LEN_LONG_MIN = 8'h1e;

   // Transmit power bands.
   typedef enum logic [1:0]
   {
      BAND_VERY_SHORT = 2'h0,
      BAND_SHORT      = 2'h1,
      BAND_MID        = 2'h2,
      BAND_LONG       = 2'h3
   } mtr_band_t;

   // Indicator flash time and its count of clock cycles.
   localparam int CLK_FREQ_MHZ  = 125;
   localparam int FLASH_TIME_US = 1000;
   localparam int FLASH_CYCLES  = FLASH_TIME_US * CLK_FREQ_MHZ;

endpackage

// File: rtl/mtr_flash.sv
`timescale 1ns/1ps
`default_nettype none
//****************************************************************************
// Indicator driver: stretches event pulses, or stays lit while forced.
//****************************************************************************
module mtr_flash
#(
   parameter int CYCLES = 1000
)
(
   input  wire logic i_clk,     // System clock.
   input  wire logic i_rst,     // Asynchronous reset, active high.
   input  wire logic i_trigger, // One-cycle event that starts a flash.
   input  wire logic i_force,   // Level that holds the lamp steadily on.
   output var  logic o_lamp     // Lamp drive, registered.
);

   logic [31:0] cnt_reg;
   logic [31:0] cnt_next;

   // Each event restarts the flash time, otherwise the time runs down.
   assign cnt_next = i_trigger ? 32'(CYCLES) : ((cnt_reg != 32'h0) ? cnt_reg - 32'h1 : 32'h0);

   // The lamp is lit while the flash runs or while forced.
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         cnt_reg <= 32'h0;
         o_lamp  <= 1'b0;
      end
      else
      begin
         cnt_reg <= cnt_next;
         o_lamp  <= i_force | (cnt_next != 32'h0);
      end
   end

endmodule
`default_nettype wire

// File: rtl/mtr_top.sv
`timescale 1ns/1ps
`default_nettype none
//****************************************************************************
// Motion task I/O handshake and optical ring configuration.
//****************************************************************************

// What this block does
// R1 - A resume request continues the interrupted motion task instead of starting a new one.
// R2 - A start request begins the task whose number stands in binary on the eight number inputs.
// R3 - The target reached output goes high once the axis is inside the target window.
// R4 - In a chained sequence the step output inverts at the start of every task after the first.
// R5 - The first task of a chained sequence sets the step output low.
// R6 - The following fault output is low while outside the following window, high otherwise.
// R7 - Each position flag is high while its own preset condition is met.
// R8 - The station address accepts only values from 0 to 63.
// R9 - Station address 0 makes the device an amplifier node of the ring.
// R10 - The rate code 2, 4, 8 or 16 selects that many megabaud, equal at both ends.
// R11 - The length code sets transmit power: 0 very short, else bands below 15, 15 to 29, 30 up.
// R12 - With a rate different from the ring master's no communication takes place.
// R13 - Telegram errors from a wrong power setting light the fault indicator.
// R14 - The receive indicator pulses for every good telegram received.
// R15 - The transmit indicator pulses for every telegram sent.
// R16 - The fault indicator flickers on light faults and stays lit when the link is gone.
// R17 - The controller keeps the task number stable around the start request.
module mtr_top
#(
   parameter int FLASH_CYCLES = mtr_pkg::FLASH_CYCLES
)
(
   input  wire logic        I_MCLK,                   // System clock, 125 MHz.
   input  wire logic        I_RST,                    // Asynchronous reset, active high.
   input  wire logic        I_PSEL,                   // APB select.
   input  wire logic        I_PENABLE,                // APB enable.
   input  wire logic        I_PWRITE,                 // APB direction, high for write.
   input  wire logic [11:0] I_PADDR,                  // APB byte address.
   input  wire logic [31:0] I_PWDATA,                 // APB write data.
   output var  logic        O_PREADY,                 // APB ready.
   output var  logic [31:0] O_PRDATA,                 // APB read data.
   output var  logic        O_PSLVERR,                // APB error.
   input  wire logic [7:0]  I_TASK_NUMBER,            // Task number pins, bit 0 lowest.
   input  wire logic        I_START_TASK_FROM_INPUTS, // Start pin.
   input  wire logic        I_RESUME_TASK_IN,         // Resume pin.
   input  wire logic        I_IN_WINDOW,              // Axis inside target window.
   input  wire logic        I_FOLLOW_OUTSIDE,         // Position outside following window.
   input  wire logic [5:0]  I_PRESET_MET,             // Preset condition per position register.
   input  wire logic        I_TASK_BEGIN,             // Pulse: a motion task begins.
   input  wire logic        I_SEQ_FIRST,              // Beginning task is first of a chain.
   input  wire logic        I_SEQ_CHAINED,            // Beginning task belongs to a chain.
   input  wire logic [4:0]  I_MASTER_RATE_CODE,       // Rate code seen on the ring.
   input  wire logic        I_LINK_LIGHT,             // Light present on the ring input.
   input  wire logic        I_TELEGRAM_RX,            // Pulse: good telegram received.
   input  wire logic        I_TELEGRAM_TX,            // Pulse: telegram sent.
   input  wire logic        I_TELEGRAM_ERR,           // Pulse: telegram error.
   output var  logic        O_START_TASK,             // Pulse: start the numbered task.
   output var  logic [7:0]  O_TASK_NUMBER,            // Number of the task to start.
   output var  logic        O_RESUME_TASK,            // Pulse: resume interrupted task.
   output var  logic        O_TARGET_REACHED_OUT,     // Target reached, high.
   output var  logic        O_SEQUENCE_STEP_TOGGLE_OUT, // Sequence step output.
   output var  logic        O_FOLLOWING_FAULT_OUT,    // Low when following error.
   output var  logic [5:0]  O_POSITION_FLAG,          // Position flags 0 to 5.
   output var  logic        O_AMPLIFIER_NODE,         // Station acts as amplifier node.
   output var  logic [4:0]  O_RING_RATE_CODE,         // Selected ring rate in megabaud.
   output var  logic [1:0]  O_TX_POWER_BAND,          // Transmit power band.
   output var  logic        O_RECEIVE_INDICATOR,      // Receive lamp.
   output var  logic        O_TRANSMIT_INDICATOR,     // Transmit lamp.
   output var  logic        O_FAULT_INDICATOR         // Fault lamp.
);

   //*************************************************************************
   // Functions.
   //*************************************************************************

   // True for the four legal ring rate codes.
   function automatic logic rate_legal(input logic [4:0] code);
      rate_legal = (code == mtr_pkg::RATE_2M) || (code == mtr_pkg::RATE_4M) ||
                   (code == mtr_pkg::RATE_8M) || (code == mtr_pkg::RATE_16M);
   endfunction

   // Maps the cable length in metres to a transmit power band.
   function automatic logic [1:0] length_band(input logic [7:0] len);
      if (len == 8'h00)
         length_band = mtr_pkg::BAND_VERY_SHORT;
      else if (len < mtr_pkg::LEN_MID_MIN)
         length_band = mtr_pkg::BAND_SHORT;
      else if (len < mtr_pkg::LEN_LONG_MIN)
         length_band = mtr_pkg::BAND_MID;
      else
         length_band = mtr_pkg::BAND_LONG;
   endfunction

   //*************************************************************************
   // Pin synchronisers.
   //*************************************************************************

   logic [9:0] pin_s1_reg;
   logic [9:0] pin_s2_reg;
   logic [9:0] pin_s3_reg;
   logic [9:0] pin_reg;
   logic [9:0] pin_prev_reg;
   logic [9:0] pin_next;

   // A pin change counts once the second and third stages agree; else the old value holds.
   assign pin_next = ((pin_s2_reg ^ pin_s3_reg) & pin_reg) |
                     (~(pin_s2_reg ^ pin_s3_reg) & pin_s3_reg);

   // Three stages per pin, then the agreed value.
   always_ff @(posedge I_MCLK or posedge I_RST)
   begin
      if (I_RST)
      begin
         pin_s1_reg   <= 10'h000;
         pin_s2_reg   <= 10'h000;
         pin_s3_reg   <= 10'h000;
         pin_reg      <= 10'h000;
         pin_prev_reg <= 10'h000;
      end
      else
      begin
         pin_s1_reg   <= {I_RESUME_TASK_IN, I_START_TASK_FROM_INPUTS, I_TASK_NUMBER};
         pin_s2_reg   <= pin_s1_reg;
         pin_s3_reg   <= pin_s2_reg;
         pin_reg      <= pin_next;
         pin_prev_reg <= pin_reg;
      end
   end

   //*************************************************************************
   // Configuration register and APB slave.
   //*************************************************************************

   logic [5:0]  station_reg;
   logic [4:0]  rate_reg;
   logic [7:0]  length_reg;
   logic        io_en_reg;
   logic        setup_phase;
   logic        wr_commit;
   logic        hit_cfg;
   logic        hit_status;
   logic        wr_cfg_ok;
   logic        bad_access;
   logic [6:0]  wr_station;
   logic [4:0]  wr_rate;
   logic [31:0] cfg_word;
   logic [31:0] status_word;
   logic [31:0] rd_word;
   logic        comm_ok;

   // Address decode and write checks.
   assign setup_phase = I_PSEL & ~I_PENABLE;
   assign wr_commit   = I_PSEL & I_PENABLE & O_PREADY & I_PWRITE & ~O_PSLVERR;
   assign hit_cfg     = (I_PADDR == mtr_pkg::REG_CFG_OFS);
   assign hit_status  = (I_PADDR == mtr_pkg::REG_STATUS_OFS);
   assign wr_station  = {1'b0, I_PWDATA[mtr_pkg::STATION_LSB +: mtr_pkg::STATION_W]};
   assign wr_rate     = I_PWDATA[mtr_pkg::RATE_LSB +: mtr_pkg::RATE_W];
   assign wr_cfg_ok   = (wr_station <= mtr_pkg::STATION_MAX) && rate_legal(wr_rate)
                        && (I_PWDATA[7:6] == 2'h0);                                        // R8
   assign bad_access  = I_PWRITE ? !(hit_cfg && wr_cfg_ok) : !(hit_cfg || hit_status);

   // Register images for reads.
   assign cfg_word = {io_en_reg, 7'h00, length_reg, 3'h0, rate_reg, 2'h0, station_reg};
   assign status_word = {8'h00, O_TASK_NUMBER, 2'h0, O_TX_POWER_BAND, I_LINK_LIGHT, comm_ok,
                         O_AMPLIFIER_NODE, O_POSITION_FLAG, O_FOLLOWING_FAULT_OUT,
                         O_SEQUENCE_STEP_TOGGLE_OUT, O_TARGET_REACHED_OUT};
   assign rd_word = hit_cfg ? cfg_word : (hit_status ? status_word : 32'h0);

   // Answer is prepared in the setup cycle, so the access phase has no wait.
   always_ff @(posedge I_MCLK or posedge I_RST)
   begin
      if (I_RST)
      begin
         O_PREADY  <= 1'b0;
         O_PRDATA  <= 32'h0;
         O_PSLVERR <= 1'b0;
      end
      else
      begin
         O_PREADY  <= setup_phase;
         O_PRDATA  <= (setup_phase && !I_PWRITE) ? rd_word : 32'h0;
         O_PSLVERR <= setup_phase && bad_access;
      end
   end

   // Configuration fields; a refused write leaves them unchanged.
   always_ff @(posedge I_MCLK or posedge I_RST)
   begin
      if (I_RST)
      begin
         station_reg <= mtr_pkg::STATION_RST;
         rate_reg    <= mtr_pkg::RATE_RST;
         length_reg  <= mtr_pkg::LENGTH_RST;
         io_en_reg   <= mtr_pkg::IO_EN_RST;
      end
      else if (wr_commit)
      begin
         station_reg <= I_PWDATA[mtr_pkg::STATION_LSB +: mtr_pkg::STATION_W];     // R8
         rate_reg    <= wr_rate;                                                 // R10
         length_reg  <= I_PWDATA[mtr_pkg::LENGTH_LSB +: mtr_pkg::LENGTH_W];       // R11
         io_en_reg   <= I_PWDATA[mtr_pkg::IO_EN_BIT];
      end
   end

   //*************************************************************************
   // Motion task handshake and status outputs.
   //*************************************************************************

   logic start_edge;
   logic resume_edge;

   // Rising edges of the agreed start and resume pins.
   assign start_edge  = io_en_reg & pin_reg[8] & ~pin_prev_reg[8];
   assign resume_edge = io_en_reg & pin_reg[9] & ~pin_prev_reg[9] & ~start_edge;

   // Start wins over a resume seen in the same cycle.
   always_ff @(posedge I_MCLK or posedge I_RST)
   begin
      if (I_RST)
      begin
         O_START_TASK               <= 1'b0;
         O_TASK_NUMBER              <= 8'h00;
         O_RESUME_TASK              <= 1'b0;
         O_TARGET_REACHED_OUT       <= 1'b0;
         O_SEQUENCE_STEP_TOGGLE_OUT <= 1'b0;
         O_FOLLOWING_FAULT_OUT      <= 1'b0;
         O_POSITION_FLAG            <= 6'h00;
      end
      else
      begin
         O_START_TASK          <= start_edge;                                    // R2
         O_RESUME_TASK         <= resume_edge;                                   // R1
         O_TARGET_REACHED_OUT  <= I_IN_WINDOW;                                   // R3
         O_FOLLOWING_FAULT_OUT <= ~I_FOLLOW_OUTSIDE;                             // R6
         O_POSITION_FLAG       <= I_PRESET_MET;                                  // R7
         if (start_edge)
            O_TASK_NUMBER <= pin_reg[7:0];                                       // R2 R17
         if (I_TASK_BEGIN && I_SEQ_FIRST)
            O_SEQUENCE_STEP_TOGGLE_OUT <= 1'b0;                                  // R5
         else if (I_TASK_BEGIN && I_SEQ_CHAINED)
            O_SEQUENCE_STEP_TOGGLE_OUT <= ~O_SEQUENCE_STEP_TOGGLE_OUT;           // R4
      end
   end

   //*************************************************************************
   // Ring configuration outputs and indicators.
   //*************************************************************************

   logic fault_force;

   // Telegrams count only when both ends run the same rate.
   assign comm_ok     = (rate_reg == I_MASTER_RATE_CODE) & I_LINK_LIGHT;         // R12
   assign fault_force = ~comm_ok;                                                // R16

   // Station role, rate and power band are registered copies of the setup.
   always_ff @(posedge I_MCLK or posedge I_RST)
   begin
      if (I_RST)
      begin
         O_AMPLIFIER_NODE <= 1'b0;
         O_RING_RATE_CODE <= mtr_pkg::RATE_RST;
         O_TX_POWER_BAND  <= mtr_pkg::BAND_VERY_SHORT;
      end
      else
      begin
         O_AMPLIFIER_NODE <= (station_reg == 6'h00);                             // R9
         O_RING_RATE_CODE <= rate_reg;                                           // R10
         O_TX_POWER_BAND  <= length_band(length_reg);                            // R11
      end
   end

   // Receive lamp flashes per good telegram.
   mtr_flash #(.CYCLES(FLASH_CYCLES)) u_rx_lamp
   (
      .i_clk     (I_MCLK),
      .i_rst     (I_RST),
      .i_trigger (I_TELEGRAM_RX & comm_ok),                                      // R14
      .i_force   (1'b0),
      .o_lamp    (O_RECEIVE_INDICATOR)
   );

   // Transmit lamp flashes per telegram sent.
   mtr_flash #(.CYCLES(FLASH_CYCLES)) u_tx_lamp
   (
      .i_clk     (I_MCLK),
      .i_rst     (I_RST),
      .i_trigger (I_TELEGRAM_TX & comm_ok),                                      // R15
      .i_force   (1'b0),
      .o_lamp    (O_TRANSMIT_INDICATOR)
   );

   // Fault lamp flickers per error and stays lit without a usable link.
   mtr_flash #(.CYCLES(FLASH_CYCLES)) u_err_lamp
   (
      .i_clk     (I_MCLK),
      .i_rst     (I_RST),
      .i_trigger (I_TELEGRAM_ERR),                                               // R13
      .i_force   (fault_force),                                                  // R16
      .o_lamp    (O_FAULT_INDICATOR)
   );

   //*************************************************************************
   // Assertions.
   //*************************************************************************

   // A start edge on the pins, then the agreed value one cycle later.
   sequence start_seen_s;
      start_edge;
   endsequence

   sequence start_issued_s;
      O_START_TASK && (O_TASK_NUMBER == $past(pin_reg[7:0]));
   endsequence

   start_task_a: assert property (@(posedge I_MCLK) disable iff (I_RST) // R2
      start_seen_s |=> start_issued_s)
      else $error("Start request not passed on with its task number.");

   resume_task_a: assert property (@(posedge I_MCLK) disable iff (I_RST) // R1
      resume_edge |=> O_RESUME_TASK && !O_START_TASK)
      else $error("Resume request not passed on alone.");

   target_follow_a: assert property (@(posedge I_MCLK) disable iff (I_RST) // R3
      I_IN_WINDOW [*2] |=> O_TARGET_REACHED_OUT && $past(O_TARGET_REACHED_OUT))
      else $error("Target reached output does not follow the window.");

   seq_first_a: assert property (@(posedge I_MCLK) disable iff (I_RST) // R5
      I_TASK_BEGIN && I_SEQ_FIRST |=> !O_SEQUENCE_STEP_TOGGLE_OUT)
      else $error("Step output not low at first task.");

   seq_toggle_a: assert property (@(posedge I_MCLK) disable iff (I_RST) // R4
      I_TASK_BEGIN && I_SEQ_CHAINED && !I_SEQ_FIRST |=>
      O_SEQUENCE_STEP_TOGGLE_OUT != $past(O_SEQUENCE_STEP_TOGGLE_OUT))
      else $error("Step output did not invert.");

   follow_fault_a: assert property (@(posedge I_MCLK) disable iff (I_RST) // R6
      I_FOLLOW_OUTSIDE |=> !O_FOLLOWING_FAULT_OUT)
      else $error("Following fault output not low.");

   pos_flags_a: assert property (@(posedge I_MCLK) disable iff (I_RST) // R7
      ##1 O_POSITION_FLAG == $past(I_PRESET_MET))
      else $error("Position flags do not follow presets.");

   station_range_a: assert property (@(posedge I_MCLK) disable iff (I_RST) // R8
      wr_commit |=> ({1'b0, station_reg} <= mtr_pkg::STATION_MAX) && rate_legal(rate_reg))
      else $error("Station or rate out of range after write.");

   amp_node_a: assert property (@(posedge I_MCLK) disable iff (I_RST) // R9
      (station_reg == 6'h00) [*2] |=> O_AMPLIFIER_NODE)
      else $error("Station zero is not an amplifier node.");

   band_short_a: assert property (@(posedge I_MCLK) disable iff (I_RST) // R11
      (length_reg == 8'h00) [*2] |-> O_TX_POWER_BAND == mtr_pkg::BAND_VERY_SHORT)
      else $error("Length zero not very short band.");

   rate_mismatch_a: assert property (@(posedge I_MCLK) disable iff (I_RST) // R12
      (rate_reg != I_MASTER_RATE_CODE) [*2] |=> O_FAULT_INDICATOR)
      else $error("Rate mismatch does not show as fault.");

   error_lamp_a: assert property (@(posedge I_MCLK) disable iff (I_RST) // R13
      I_TELEGRAM_ERR |-> ##[1:2] O_FAULT_INDICATOR)
      else $error("Telegram error did not light fault lamp.");

   rx_lamp_a: assert property (@(posedge I_MCLK) disable iff (I_RST) // R14
      I_TELEGRAM_RX && comm_ok |-> ##[1:2] O_RECEIVE_INDICATOR)
      else $error("Received telegram did not flash lamp.");

   tx_lamp_a: assert property (@(posedge I_MCLK) disable iff (I_RST) // R15
      I_TELEGRAM_TX && comm_ok |-> ##[1:2] O_TRANSMIT_INDICATOR)
      else $error("Sent telegram did not flash lamp.");

   link_lost_a: assert property (@(posedge I_MCLK) disable iff (I_RST) // R16
      !I_LINK_LIGHT [*2] |=> O_FAULT_INDICATOR)
      else $error("Fault lamp not steady without link.");

   rate_out_a: assert property (@(posedge I_MCLK) disable iff (I_RST) // R10
      $changed(rate_reg) |=> O_RING_RATE_CODE == $past(rate_reg))
      else $error("Ring rate output not the set code.");

endmodule
`default_nettype wire

// File: verif/mtr_partner.sv
`timescale 1ns/1ps
`default_nettype none
//****************************************************************************
// Controller model: sets the task number, then pulses the start pin.
//****************************************************************************
module mtr_partner
(
   input  wire logic       i_clk,   // System clock.
   input  wire logic       i_rst,   // Asynchronous reset, active high.
   input  wire logic       i_go,    // Request to start a task.
   input  wire logic [7:0] i_num,   // Task number to present.
   output var  logic [7:0] o_num,   // Task number pins.
   output var  logic       o_start  // Start pin.
);
   logic [3:0] cnt_reg;
   // The number leads the start pin by four cycles and stays until the next request.
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         cnt_reg <= 4'h0;
         o_num   <= 8'h00;
         o_start <= 1'b0;
      end
      else
      begin
         if (i_go) o_num <= i_num;
         cnt_reg <= i_go ? 4'hc : cnt_reg - {3'h0, |cnt_reg};
         o_start <= (cnt_reg != 4'h0) && (cnt_reg < 4'ha);
      end
   end
endmodule
`default_nettype wire

// File: verif/test_mtr_top.sv
`timescale 1ns/1ps
`default_nettype none
module test_mtr_top;
   logic I_MCLK, I_RST, I_PSEL, I_PENABLE, I_PWRITE, I_RESUME_TASK_IN, I_IN_WINDOW, go;
   logic I_FOLLOW_OUTSIDE, I_TASK_BEGIN, I_SEQ_FIRST, I_SEQ_CHAINED, I_LINK_LIGHT, err;
   logic I_TELEGRAM_RX, I_TELEGRAM_TX, I_TELEGRAM_ERR, I_START_TASK_FROM_INPUTS, O_PREADY;
   logic O_PSLVERR, O_START_TASK, O_RESUME_TASK, O_TARGET_REACHED_OUT, O_AMPLIFIER_NODE;
   logic O_SEQUENCE_STEP_TOGGLE_OUT, O_FOLLOWING_FAULT_OUT, O_RECEIVE_INDICATOR;
   logic O_TRANSMIT_INDICATOR, O_FAULT_INDICATOR;
   logic [11:0] I_PADDR;
   logic [31:0] I_PWDATA, O_PRDATA, rd;
   logic [7:0]  I_TASK_NUMBER, O_TASK_NUMBER, num;
   logic [5:0]  I_PRESET_MET, O_POSITION_FLAG;
   logic [4:0]  I_MASTER_RATE_CODE, O_RING_RATE_CODE;
   logic [1:0]  O_TX_POWER_BAND;
   int          bad_count, total_checks, i;
   mtr_top #(.FLASH_CYCLES(8)) mtr_top_inst (.*);
   mtr_partner mtr_partner_inst (.i_clk(I_MCLK), .i_rst(I_RST), .i_go(go), .i_num(num),
      .o_num(I_TASK_NUMBER), .o_start(I_START_TASK_FROM_INPUTS));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin bad_count++; $display("mismatch %0t got %h exp %h", $time, got, exp); end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge I_MCLK) {I_PSEL, I_PENABLE, I_PWRITE, I_PADDR, I_PWDATA} <= {2'b10, w, a, d};
      @(posedge I_MCLK) I_PENABLE <= 1'b1;
      for (i = 0; i < 20 && O_PREADY !== 1'b1; i++) @(posedge I_MCLK);
      chk(O_PREADY, 1'b1);
      rd = O_PRDATA; err = O_PSLVERR; {I_PSEL, I_PENABLE} <= 2'b00;
   endtask
   task automatic t_regs(input logic [7:0] len, input logic [4:0] rate, input logic [1:0] band);
      apb(1'b1, 12'h000, {8'h80, len, 3'h0, rate, 8'h00}); chk(err, 0);
      @(negedge I_MCLK) @(negedge I_MCLK);
      chk(O_TX_POWER_BAND, band); chk(O_RING_RATE_CODE, rate); chk(O_AMPLIFIER_NODE, 1);
   endtask
   task automatic pulse(input logic [2:0] ev);
      @(posedge I_MCLK) {I_TELEGRAM_RX, I_TELEGRAM_TX, I_TELEGRAM_ERR} <= ev;
      @(posedge I_MCLK) {I_TELEGRAM_RX, I_TELEGRAM_TX, I_TELEGRAM_ERR} <= 3'h0;
      @(negedge I_MCLK);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Clock of 125 MHz.
   initial begin I_MCLK = 1'b0; forever #4 I_MCLK = ~I_MCLK; end
   // Watchdog against a hang.
   initial begin #200000; bad_count++; conclude(); end
   // Main sequence.
   initial
   begin
      {I_RST, I_PSEL, I_PENABLE, I_PWRITE, I_RESUME_TASK_IN, I_IN_WINDOW, go} = 7'h40;
      {I_FOLLOW_OUTSIDE, I_TASK_BEGIN, I_SEQ_FIRST, I_SEQ_CHAINED, I_LINK_LIGHT} = 5'h0;
      {I_TELEGRAM_RX, I_TELEGRAM_TX, I_TELEGRAM_ERR, I_PADDR, I_PWDATA, num} = '0;
      {I_PRESET_MET, I_MASTER_RATE_CODE, bad_count, total_checks} = '0;
      repeat (10) @(posedge I_MCLK);
      I_RST <= 1'b0;
      apb(1'b0, 12'h000, 32'h0); chk(rd, 32'h8000_0200);
      t_regs(8'h00, 5'h02, 2'h0); t_regs(8'h0e, 5'h04, 2'h1);
      t_regs(8'h0f, 5'h08, 2'h2); t_regs(8'h1e, 5'h10, 2'h3);
      apb(1'b1, 12'h000, 32'h801e_1040); chk(err, 1);
      apb(1'b1, 12'h000, 32'h801e_0300); chk(err, 1);
      apb(1'b0, 12'h000, 32'h0); chk(rd, 32'h801e_1000);
      apb(1'b0, 12'h008, 32'h0); chk(err, 1); chk(rd, 32'h0);
      apb(1'b1, 12'h000, 32'h801e_103f); chk(err, 0); repeat (2) @(negedge I_MCLK);
      chk(O_AMPLIFIER_NODE, 0);
      @(posedge I_MCLK) {go, num} <= {1'b1, 8'hae};
      @(posedge I_MCLK) go <= 1'b0;
      for (i = 0; i < 30 && O_START_TASK !== 1'b1; i++) @(negedge I_MCLK);
      chk({O_START_TASK, O_TASK_NUMBER}, {1'b1, 8'hae});
      @(posedge I_MCLK) I_RESUME_TASK_IN <= 1'b1;
      for (i = 0; i < 30 && O_RESUME_TASK !== 1'b1; i++) @(negedge I_MCLK);
      chk({O_RESUME_TASK, O_START_TASK}, 2'b10);
      @(posedge I_MCLK) I_RESUME_TASK_IN <= 1'b0;
      @(posedge I_MCLK) {I_IN_WINDOW, I_FOLLOW_OUTSIDE, I_PRESET_MET} <= 8'he5;
      @(posedge I_MCLK) I_FOLLOW_OUTSIDE <= 1'b0;
      @(negedge I_MCLK) chk({O_TARGET_REACHED_OUT, O_FOLLOWING_FAULT_OUT}, 2'b10);
      chk(O_POSITION_FLAG, 6'h25);
      @(negedge I_MCLK) chk(O_FOLLOWING_FAULT_OUT, 1);
      apb(1'b0, 12'h004, 32'h0); chk(rd, 32'h00ae_312d);
      for (int k = 0; k < 4; k++)
      begin
         @(posedge I_MCLK) {I_TASK_BEGIN, I_SEQ_FIRST, I_SEQ_CHAINED} <= {1'b1, k % 3 == 0, 1'b1};
         @(posedge I_MCLK) I_TASK_BEGIN <= 1'b0;
         @(negedge I_MCLK) chk(O_SEQUENCE_STEP_TOGGLE_OUT, (k == 1));
      end
      @(posedge I_MCLK) {I_LINK_LIGHT, I_MASTER_RATE_CODE} <= {1'b1, 5'h10};
      repeat (3) @(negedge I_MCLK); chk(O_FAULT_INDICATOR, 0);
      for (int k = 0; k < 3; k++)
      begin
         pulse(3'h4 >> k);
         chk({O_RECEIVE_INDICATOR, O_TRANSMIT_INDICATOR, O_FAULT_INDICATOR}, 3'h4 >> k);
         repeat (11) @(negedge I_MCLK);
         chk({O_RECEIVE_INDICATOR, O_TRANSMIT_INDICATOR, O_FAULT_INDICATOR}, 0);
      end
      @(posedge I_MCLK) I_LINK_LIGHT <= 1'b0;
      repeat (2) @(negedge I_MCLK); chk(O_FAULT_INDICATOR, 1);
      @(posedge I_MCLK) {I_LINK_LIGHT, I_MASTER_RATE_CODE} <= {1'b1, 5'h02};
      pulse(3'h4); chk({O_RECEIVE_INDICATOR, O_FAULT_INDICATOR}, 2'b01);
      // With the pin interface switched off a start on the pins is ignored.
      apb(1'b1, 12'h000, 32'h001e_1000); chk(err, 0);
      @(posedge I_MCLK) {go, num} <= {1'b1, 8'h35};
      @(posedge I_MCLK) go <= 1'b0;
      for (i = 0; i < 30 && O_START_TASK !== 1'b1; i++) @(negedge I_MCLK);
      chk({O_START_TASK, O_TASK_NUMBER}, {1'b0, 8'hae});
      conclude();
   end
endmodule
`default_nettype wire
